// File: rtl/swc_consts.svh
// Purpose: offsets, field positions and reset values of the sleep controller
// Assumes: included by its bare name
// Notes: definitions only
`ifndef SWC_CONSTS_SVH
`define SWC_CONSTS_SVH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define SWC_CTRL_OFS 32'h0000_0000
`define SWC_STAT_OFS 32'h0000_0004
// ****************************************
// control word fields
// ****************************************
`define SWC_CTRL_EXIT_BIT 1
`define SWC_CTRL_DEEP_BIT 2
`define SWC_CTRL_SEVP_BIT 4
`define SWC_CTRL_RST 32'h0000_0000
// ****************************************
// status word fields
// ****************************************
`define SWC_STAT_SLEEP_BIT 0
`define SWC_STAT_DEEP_BIT 1
`define SWC_STAT_CAUSE_LSB 2
`define SWC_STAT_CAUSE_MSB 3
`define SWC_STAT_WCNT_LSB 8
`define SWC_STAT_WCNT_MSB 15
// ****************************************
// bus response codes
// ****************************************
`define SWC_RESP_OKAY 2'h0
`define SWC_RESP_SLVERR 2'h2
`endif

// File: rtl/swc_pkg.sv
// Purpose: types shared by the sleep controller files
// Assumes: nothing
// Notes: codes written out, one code of the state enum unused
package swc_pkg;
  // controller state
  typedef enum logic [1:0] {
    SWC_ST_RUN = 2'b00,
    SWC_ST_SLP_INT = 2'b01,
    SWC_ST_SLP_EVT = 2'b10
  } swc_state_e;
  // what caused the last sleep entry
  typedef enum logic [1:0] {
    SWC_CAUSE_NONE = 2'b00,
    SWC_CAUSE_WINT = 2'b01,
    SWC_CAUSE_EXIT = 2'b10,
    SWC_CAUSE_WEVT = 2'b11
  } swc_cause_e;
endpackage : swc_pkg

// File: rtl/swc_wake_eval.sv
// Purpose: decides whether a pending exception may be taken or may wake
// Assumes: lower priority number means more urgent; zero base limit = off
// Notes: purely combinational, registered by the caller
`timescale 1ns/1ps
module swc_wake_eval #(
  parameter int PRIO_W = 8
) (
  // pending exceptions
  input wire logic nmi_pend_i,
  input wire logic hard_pend_i,
  input wire logic irq_pend_i,
  input wire logic [PRIO_W-1:0] irq_prio_i,
  // current execution priority and masks
  input wire logic [PRIO_W-1:0] cur_prio_i,
  input wire logic [PRIO_W-1:0] base_prio_i,
  input wire logic prio_mask_i,
  input wire logic fault_mask_i,
  // decisions
  output logic exc_take_o,
  output logic exc_wake_o
);
  logic above_cur;
  logic base_ok;
  logic irq_take;
  logic hard_take;
  // priority must beat the current level and every mask limit
  assign above_cur = irq_prio_i < cur_prio_i;
  assign base_ok = (base_prio_i == '0) || (irq_prio_i < base_prio_i);
  assign irq_take = irq_pend_i && above_cur && base_ok && !prio_mask_i && !fault_mask_i;
  // fault mask also holds back the hard fault, never the nmi
  assign hard_take = hard_pend_i && !fault_mask_i;
  assign exc_take_o = nmi_pend_i || hard_take || irq_take;
  // priority mask alone still lets a good interrupt wake, handler deferred
  assign exc_wake_o = exc_take_o ||
                      (irq_pend_i && above_cur && base_ok && prio_mask_i && !fault_mask_i);
endmodule : swc_wake_eval

// File: rtl/swc_axil_regs.sv
// Purpose: axi4-lite slave holding the control word and reading status
// Assumes: one write and one read outstanding at most
// Notes: unmapped addresses answer slverr, reads of them return zero
`timescale 1ns/1ps
`include "swc_consts.svh"
module swc_axil_regs #(
  parameter int ADDR_W = 4
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // register contents
  output logic [31:0] ctrl_o,
  input wire logic [31:0] status_i
);
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic w_lane0;
  logic do_wr;
  logic wr_ctrl;
  logic wr_ok;
  logic [ADDR_W-1:0] ar_word;
  // address and data are taken in either order; blocked while b is out
  assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_held && !s_axi_bvalid_o;
  assign s_axi_arready_o = !s_axi_rvalid_o;
  assign do_wr = aw_held && w_held;
  assign wr_ctrl = {aw_addr[ADDR_W-1:2], 2'b00} == ADDR_W'(`SWC_CTRL_OFS);
  // status is read only, a write to it is accepted and dropped
  assign wr_ok = wr_ctrl || ({aw_addr[ADDR_W-1:2], 2'b00} == ADDR_W'(`SWC_STAT_OFS));
  assign ar_word = {s_axi_araddr_i[ADDR_W-1:2], 2'b00};
  // write address holding
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (do_wr) begin
      aw_held <= 1'b0;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr_i;
    end
  end
  // write data holding; all control bits live in byte lane 0
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_lane0 <= 1'b0;
    end else if (do_wr) begin
      w_held <= 1'b0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata_i;
      w_lane0 <= s_axi_wstrb_i[0];
    end
  end
  // control word, only its three defined bits are stored
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      ctrl_o <= `SWC_CTRL_RST;
    end else if (do_wr && wr_ctrl && w_lane0) begin
      ctrl_o <= 32'h0000_0000;
      ctrl_o[`SWC_CTRL_EXIT_BIT] <= w_data[`SWC_CTRL_EXIT_BIT];
      ctrl_o[`SWC_CTRL_DEEP_BIT] <= w_data[`SWC_CTRL_DEEP_BIT];
      ctrl_o[`SWC_CTRL_SEVP_BIT] <= w_data[`SWC_CTRL_SEVP_BIT];
    end
  end
  // write response, one cycle after both halves are held
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `SWC_RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= wr_ok ? `SWC_RESP_OKAY : `SWC_RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end
  // read answer registered at the address handshake
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= `SWC_RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      if (ar_word == ADDR_W'(`SWC_CTRL_OFS)) begin
        s_axi_rdata_o <= ctrl_o;
        s_axi_rresp_o <= `SWC_RESP_OKAY;
      end else if (ar_word == ADDR_W'(`SWC_STAT_OFS)) begin
        s_axi_rdata_o <= status_i;
        s_axi_rresp_o <= `SWC_RESP_OKAY;
      end else begin
        s_axi_rdata_o <= '0;
        s_axi_rresp_o <= `SWC_RESP_SLVERR;
      end
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end
endmodule : swc_axil_regs

// File: rtl/swc_sleep_ctrl.sv
// Purpose: sleep entry and wakeup control for the processor core
// Assumes: instruction strobes are one-cycle pulses, at most one per cycle
// Notes: registers over axi4-lite; the event latch has no bus path
// Operation
// - shallow sleep gates only the core clock, other clocks keep running
// - deep sleep requests that most system and peripheral clocks stop
// - deep select control bit chooses deep or shallow sleep at entry
// - wait-for-interrupt stops issue and sleeps at once, unconditionally
// - wait-for-event with event latch clear stops issue and sleeps
// - wait-for-event with latch set clears it and keeps running
// - event latch is one bit, unreachable by software
// - external event or any send-event sets the event latch
// - with sleep-after-handler set, return to thread mode sleeps
// - interrupt-type sleep wakes only on an exception able to enter; here dbg_wake_i wakes it too
// - priority mask alone still lets an enabled higher interrupt wake
// - event-type sleep wakes on enterable exception or external event
// - pending-raises-event makes every new pending interrupt an event
// - external event wakes event sleep, else sets the latch
// - sufficient priority means beating every mask limit
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "swc_consts.svh"
module swc_sleep_ctrl #(
  parameter int ADDR_W = 4,
  parameter int PRIO_W = 8
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // axi4-lite write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // instruction execution strobes
  input wire logic wait_int_i,
  input wire logic wait_evt_i,
  input wire logic send_evt_i,
  input wire logic exit_to_thread_i,
  // events from outside the core
  input wire logic peer_evt_i,
  input wire logic ext_event_i,
  input wire logic irq_new_pend_i,
  input wire logic dbg_wake_i,
  // exception state
  input wire logic nmi_pend_i,
  input wire logic hard_pend_i,
  input wire logic irq_pend_i,
  input wire logic [PRIO_W-1:0] irq_prio_i,
  input wire logic [PRIO_W-1:0] cur_prio_i,
  input wire logic [PRIO_W-1:0] base_prio_i,
  input wire logic priority_mask_all_i,
  input wire logic fault_mask_all_i,
  // towards the core
  output logic issue_stop_o,
  output logic exc_take_o,
  output logic wait_skip_o,
  output logic wake_o,
  output logic evt_out_o,
  // towards the clock controller
  output logic core_clk_gate_o,
  output logic sys_clk_stop_o,
  output logic sleeping_o,
  output logic deep_sleep_o
);
  // ****************************************
  // declarations
  // ****************************************
  swc_pkg::swc_state_e state;
  swc_pkg::swc_state_e next_state;
  swc_pkg::swc_cause_e cause;
  logic [31:0] ctrl;
  logic [31:0] status;
  logic deep_sleep_select;
  logic sleep_after_handler;
  logic pending_raises_event;
  logic event_latch;
  logic exc_take;
  logic exc_wake;
  logic pend_event;
  logic any_event;
  logic enter_exit;
  logic enter_wint;
  logic enter_wevt;
  logic skip_wevt;
  logic wake_now;
  logic deep_hold;
  logic [7:0] wake_cnt;

  // ****************************************
  // register slave
  // ****************************************
  swc_axil_regs #(
    .ADDR_W(ADDR_W)
  ) u_regs (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .s_axi_awaddr_i(s_axi_awaddr_i),
    .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wdata_i(s_axi_wdata_i),
    .s_axi_wstrb_i(s_axi_wstrb_i),
    .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bresp_o(s_axi_bresp_o),
    .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i),
    .s_axi_araddr_i(s_axi_araddr_i),
    .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rdata_o(s_axi_rdata_o),
    .s_axi_rresp_o(s_axi_rresp_o),
    .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i),
    .ctrl_o(ctrl),
    .status_i(status)
  );

  // control bits of the system control word
  assign deep_sleep_select = ctrl[`SWC_CTRL_DEEP_BIT];
  assign sleep_after_handler = ctrl[`SWC_CTRL_EXIT_BIT];
  assign pending_raises_event = ctrl[`SWC_CTRL_SEVP_BIT];

  // status word; the event latch is left out on purpose
  always_comb begin
    status = 32'h0000_0000;
    status[`SWC_STAT_SLEEP_BIT] = sleeping_o;
    status[`SWC_STAT_DEEP_BIT] = deep_sleep_o;
    status[`SWC_STAT_CAUSE_MSB:`SWC_STAT_CAUSE_LSB] = cause;
    status[`SWC_STAT_WCNT_MSB:`SWC_STAT_WCNT_LSB] = wake_cnt;
  end

  // ****************************************
  // exception priority evaluation
  // ****************************************
  swc_wake_eval #(
    .PRIO_W(PRIO_W)
  ) u_eval (
    .nmi_pend_i(nmi_pend_i),
    .hard_pend_i(hard_pend_i),
    .irq_pend_i(irq_pend_i),
    .irq_prio_i(irq_prio_i),
    .cur_prio_i(cur_prio_i),
    .base_prio_i(base_prio_i),
    .prio_mask_i(priority_mask_all_i),
    .fault_mask_i(fault_mask_all_i),
    .exc_take_o(exc_take),
    .exc_wake_o(exc_wake)
  );

  // ****************************************
  // events and entry decisions
  // ****************************************
  // a new pending interrupt counts as an event only when enabled by software
  assign pend_event = pending_raises_event && irq_new_pend_i;
  // own and peer send-event both count, as does the line event input
  assign any_event = ext_event_i || peer_evt_i || send_evt_i || pend_event;
  // sleep after handler wins over an instruction strobe in the same cycle
  assign enter_exit = (state == swc_pkg::SWC_ST_RUN) && exit_to_thread_i &&
                      sleep_after_handler;
  assign enter_wint = (state == swc_pkg::SWC_ST_RUN) && wait_int_i &&
                      !enter_exit;
  assign enter_wevt = (state == swc_pkg::SWC_ST_RUN) && wait_evt_i && !event_latch &&
                      !enter_exit && !wait_int_i;
  assign skip_wevt = (state == swc_pkg::SWC_ST_RUN) && wait_evt_i && event_latch &&
                     !enter_exit && !wait_int_i;

  // wake terms per sleep kind; debug may wake either, software copes
  always_comb begin
    wake_now = 1'b0;
    unique case (state)
      swc_pkg::SWC_ST_SLP_INT: wake_now = exc_wake || dbg_wake_i;
      swc_pkg::SWC_ST_SLP_EVT: wake_now = exc_wake || any_event ||
                                         event_latch || dbg_wake_i;
      default: wake_now = 1'b0;
    endcase
  end

  // ****************************************
  // state machine
  // ****************************************
  // next state from entry and wake terms
  always_comb begin
    next_state = state;
    unique case (state)
      swc_pkg::SWC_ST_RUN: begin
        if (enter_exit || enter_wint) begin
          next_state = swc_pkg::SWC_ST_SLP_INT;
        end else if (enter_wevt) begin
          next_state = swc_pkg::SWC_ST_SLP_EVT;
        end
      end
      swc_pkg::SWC_ST_SLP_INT: begin
        if (wake_now) begin
          next_state = swc_pkg::SWC_ST_RUN;
        end
      end
      swc_pkg::SWC_ST_SLP_EVT: begin
        if (wake_now) begin
          next_state = swc_pkg::SWC_ST_RUN;
        end
      end
      default: next_state = swc_pkg::SWC_ST_RUN;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      state <= swc_pkg::SWC_ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // event latch
  // ****************************************
  // set wins over the clear of a skipped wait; an event met while in
  // event sleep is used up by the wake itself instead of being stored
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      event_latch <= 1'b0;
    end else if (any_event && (state != swc_pkg::SWC_ST_SLP_EVT)) begin
      event_latch <= 1'b1;
    end else if (skip_wevt) begin
      event_latch <= 1'b0;
    end else if ((state == swc_pkg::SWC_ST_SLP_EVT) && wake_now) begin
      event_latch <= 1'b0;
    end
  end

  // ****************************************
  // sleep flags and clock requests
  // ****************************************
  // deep choice is frozen at entry so a later write cannot flip a sleep
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      deep_hold <= 1'b0;
    end else if (enter_exit || enter_wint || enter_wevt) begin
      deep_hold <= deep_sleep_select;
    end else if (wake_now) begin
      deep_hold <= 1'b0;
    end
  end

  // indications to the clock controller, all from flops
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      sleeping_o <= 1'b0;
      deep_sleep_o <= 1'b0;
      core_clk_gate_o <= 1'b0;
      sys_clk_stop_o <= 1'b0;
    end else begin
      sleeping_o <= next_state != swc_pkg::SWC_ST_RUN;
      deep_sleep_o <= (next_state != swc_pkg::SWC_ST_RUN) &&
                      (wake_now ? 1'b0 : (deep_hold || ((state ==
                      swc_pkg::SWC_ST_RUN) && deep_sleep_select)));
      core_clk_gate_o <= next_state != swc_pkg::SWC_ST_RUN;
      sys_clk_stop_o <= (next_state != swc_pkg::SWC_ST_RUN) &&
                        (wake_now ? 1'b0 : (deep_hold || ((state ==
                        swc_pkg::SWC_ST_RUN) && deep_sleep_select)));
    end
  end

  // issue halts while any sleep state is held
  assign issue_stop_o = state != swc_pkg::SWC_ST_RUN;

  // ****************************************
  // pulses and bookkeeping
  // ****************************************
  // one-cycle strobes to core and peer processors, plus the registered take decision
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      wait_skip_o <= 1'b0;
      wake_o <= 1'b0;
      evt_out_o <= 1'b0;
      exc_take_o <= 1'b0;
    end else begin
      wait_skip_o <= skip_wevt;
      wake_o <= wake_now;
      evt_out_o <= send_evt_i;
      exc_take_o <= exc_take;
    end
  end

  // last entry cause, kept across the wake for software to read
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      cause <= swc_pkg::SWC_CAUSE_NONE;
    end else if (enter_exit) begin
      cause <= swc_pkg::SWC_CAUSE_EXIT;
    end else if (enter_wint) begin
      cause <= swc_pkg::SWC_CAUSE_WINT;
    end else if (enter_wevt) begin
      cause <= swc_pkg::SWC_CAUSE_WEVT;
    end
  end

  // wake counter wraps; lets an idle loop spot spurious wakes
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      wake_cnt <= 8'h00;
    end else if (wake_now) begin
      wake_cnt <= wake_cnt + 8'h01;
    end
  end
endmodule : swc_sleep_ctrl

// File: test/swc_evt_ctl.sv
// Purpose: line event controller model feeding the core event input
// Assumes: sources active high, level or pulse
// Notes: registered, so an event reaches the core one cycle late
`timescale 1ns/1ps
module swc_evt_ctl (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // sixteen lines, then voltage detector, alarm and usb wakeup
  input wire logic [18:0] src_i,
  // towards the core
  output logic evt_o
);
  // any source raises the event; no masking, so every source is seen
  always_ff @(posedge clk_sys_i) begin
    evt_o <= rstn_i & (|src_i);
  end
endmodule : swc_evt_ctl

// File: test/swc_sleep_ctrl_chk.sv
// Purpose: port-level checks of the sleep controller
// Assumes: one clock, synchronous active-low reset
// Notes: bound to the top module
`timescale 1ns/1ps
module swc_sleep_ctrl_chk (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // core side inputs
  input wire logic wait_int_i,
  input wire logic wait_evt_i,
  input wire logic send_evt_i,
  input wire logic exit_to_thread_i,
  input wire logic nmi_pend_i,
  input wire logic hard_pend_i,
  input wire logic irq_pend_i,
  input wire logic priority_mask_all_i,
  // outputs watched
  input wire logic issue_stop_o,
  input wire logic exc_take_o,
  input wire logic wait_skip_o,
  input wire logic wake_o,
  input wire logic evt_out_o,
  input wire logic core_clk_gate_o,
  input wire logic sys_clk_stop_o,
  input wire logic sleeping_o,
  input wire logic deep_sleep_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  chk_gate_only_core: assert property (core_clk_gate_o == sleeping_o)
    else $error("core gate differs from sleeping");
  chk_deep_in_sleep: assert property (deep_sleep_o |-> sleeping_o && sys_clk_stop_o)
    else $error("deep request outside sleep");
  chk_wint_enters: assert property (!issue_stop_o && wait_int_i |=> sleeping_o)
    else $error("wait-for-interrupt did not sleep");
  chk_wevt_outcome: assert property (!issue_stop_o && wait_evt_i && !wait_int_i &&
    !exit_to_thread_i |=> sleeping_o != wait_skip_o)
    else $error("wait-for-event neither slept nor skipped");
  chk_send_to_peers: assert property (!issue_stop_o && send_evt_i |=> evt_out_o)
    else $error("send-event not passed on");
  chk_nmi_taken: assert property (nmi_pend_i |=> exc_take_o)
    else $error("nmi not taken");
  chk_mask_defers: assert property (irq_pend_i && priority_mask_all_i && !nmi_pend_i &&
    !hard_pend_i |=> !exc_take_o)
    else $error("masked interrupt taken");
  chk_issue_stopped: assert property (issue_stop_o == sleeping_o)
    else $error("issue stop differs from sleeping");
  chk_wake_pulse: assert property ($fell(sleeping_o) |-> ##[0:1] wake_o)
    else $error("no wake pulse after sleep ended");
endmodule : swc_sleep_ctrl_chk
bind swc_sleep_ctrl swc_sleep_ctrl_chk i_swc_sleep_ctrl_chk (.*);

// File: test/tb_swc_sleep_ctrl.sv
// Purpose: self-checking bench of the sleep controller
// Assumes: 10 MHz clock, reset held 8 cycles
// Notes: a small model tracks latch, state and status word
`timescale 1ns/1ps
`include "swc_consts.svh"
module tb_swc_sleep_ctrl;
  logic clk_sys_i = 1'b0, rstn_i = 1'b0, ext_event_i;
  logic [3:0] s_axi_awaddr_i = 4'h0, s_axi_araddr_i = 4'h0, s_axi_wstrb_i = 4'h0;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, r;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, m_cause = 2'h0;
  logic wait_int_i = 1'b0, wait_evt_i = 1'b0, send_evt_i = 1'b0, exit_to_thread_i = 1'b0;
  logic peer_evt_i = 1'b0, irq_new_pend_i = 1'b0, dbg_wake_i = 1'b0, nmi_pend_i = 1'b0;
  logic hard_pend_i = 1'b0, irq_pend_i = 1'b0, priority_mask_all_i = 1'b0;
  logic fault_mask_all_i = 1'b0, m_slp = 1'b0, m_deep = 1'b0;
  logic [7:0] irq_prio_i = 8'h0, cur_prio_i = 8'hff, base_prio_i = 8'h0, m_wcnt = 8'h0;
  logic [18:0] src = 19'h0;
  logic issue_stop_o, exc_take_o, wait_skip_o, wake_o, evt_out_o;
  logic core_clk_gate_o, sys_clk_stop_o, sleeping_o, deep_sleep_o;
  int mismatches = 0, n_tests = 0, m_latch = 0;
  // design and the event source that sits outside it
  swc_sleep_ctrl i_swc_sleep_ctrl (.*);
  swc_evt_ctl i_swc_evt_ctl (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .src_i(src),
    .evt_o(ext_event_i));
  // clock
  initial forever #50 clk_sys_i = ~clk_sys_i;
  task automatic end_of_test;
    if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: %h, expected %h", $time, g, e);
    end
  endtask : chk
  // bus write: both halves offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_wstrb_i <= 4'($urandom) | 4'h1;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (s_axi_bvalid_o !== 1'b1);
    s_axi_bready_i <= 1'b0;
    chk({30'h0, s_axi_bresp_o}, {30'h0, e});
    @(posedge clk_sys_i);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (s_axi_rvalid_o !== 1'b1);
    s_axi_rready_i <= 1'b0;
    chk(s_axi_rdata_o, e);
    chk({30'h0, s_axi_rresp_o}, {30'h0, er});
    @(posedge clk_sys_i);
  endtask : rd
  // pins and status word against the model
  task automatic pins;
    chk({27'h0, sleeping_o, deep_sleep_o, issue_stop_o, core_clk_gate_o, sys_clk_stop_o},
      {27'h0, m_slp, m_deep, m_slp, m_slp, m_deep});
    rd(4'h4, {16'h0, m_wcnt, 4'h0, m_cause, m_deep, m_slp}, `SWC_RESP_OKAY);
  endtask : pins
  task automatic went(input logic [1:0] c, input logic d);
    m_slp = 1'b1;
    m_deep = d;
    m_cause = c;
  endtask : went
  task automatic woke;
    m_slp = 1'b0;
    m_deep = 1'b0;
    m_wcnt++;
  endtask : woke
  // strobes are one cycle; the second edge lets entry land
  task automatic core(input logic [3:0] s);
    {exit_to_thread_i, send_evt_i, wait_evt_i, wait_int_i} <= s;
    @(posedge clk_sys_i);
    {exit_to_thread_i, send_evt_i, wait_evt_i, wait_int_i} <= 4'h0;
    @(posedge clk_sys_i);
  endtask : core
  task automatic wevt_do;
    core(4'h2);
    if (m_latch != 0) m_latch = 0;
    else went(2'h3, 1'b0);
  endtask : wevt_do
  task automatic pls(input logic [3:0] s);
    {irq_new_pend_i, dbg_wake_i, peer_evt_i, nmi_pend_i} <= s;
    @(posedge clk_sys_i);
    {irq_new_pend_i, dbg_wake_i, peer_evt_i, nmi_pend_i} <= 4'h0;
    @(posedge clk_sys_i);
  endtask : pls
  // random source of the line controller; one extra edge for its register
  task automatic ext;
    src <= 19'h1 << ($urandom % 19);
    @(posedge clk_sys_i);
    src <= 19'h0;
    repeat (2) @(posedge clk_sys_i);
    if (m_slp && m_cause == 2'h3) woke;
    else m_latch = 1;
  endtask : ext
  initial begin
    r = $urandom(32'hc028);
    repeat (8) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    @(posedge clk_sys_i);
    rd(4'h0, 32'h0, `SWC_RESP_OKAY);
    rd(4'h8, 32'h0, `SWC_RESP_SLVERR);
    wr(4'hc, 32'h0, `SWC_RESP_SLVERR);
    r = $urandom;
    wr(4'h0, r, `SWC_RESP_OKAY);
    rd(4'h0, r & 32'h16, `SWC_RESP_OKAY);
    wr(4'h4, 32'hffff_ffff, `SWC_RESP_OKAY);
    wr(4'h0, 32'h0, `SWC_RESP_OKAY);
    pins;
    // interrupt sleep ignores the event input but latches it
    core(4'h1);
    went(2'h1, 1'b0);
    pins;
    ext;
    pins;
    pls(4'h1);
    woke;
    pins;
    wevt_do;
    pins;
    wevt_do;
    pins;
    ext;
    pins;
    pls(4'h2);
    m_latch = 1;
    wevt_do;
    pins;
    core(4'h4);
    m_latch = 1;
    wevt_do;
    pins;
    wevt_do;
    pls(4'h4);
    woke;
    wevt_do;
    pins;
    pls(4'h2);
    woke;
    pins;
    // deep sleep, woken by an interrupt held back by the priority mask
    wr(4'h0, 32'h4, `SWC_RESP_OKAY);
    core(4'h1);
    went(2'h1, 1'b1);
    pins;
    priority_mask_all_i <= 1'b1;
    // zero is kept out: as a base limit it would mean no limit at all
    irq_prio_i <= 8'($urandom % 254) + 8'h01;
    irq_pend_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    woke;
    chk({31'h0, exc_take_o}, 32'h0);
    pins;
    priority_mask_all_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    chk({31'h0, exc_take_o}, 32'h1);
    base_prio_i <= irq_prio_i;
    repeat (2) @(posedge clk_sys_i);
    chk({31'h0, exc_take_o}, 32'h0);
    // hard fault held back by the fault mask, taken once it drops
    fault_mask_all_i <= 1'b1;
    hard_pend_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    chk({31'h0, exc_take_o}, 32'h0);
    fault_mask_all_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    chk({31'h0, exc_take_o}, 32'h1);
    hard_pend_i <= 1'b0;
    base_prio_i <= 8'h0;
    irq_pend_i <= 1'b0;
    // sleep after handler, and new pending interrupts as events
    wr(4'h0, 32'h12, `SWC_RESP_OKAY);
    core(4'h8);
    went(2'h2, 1'b0);
    pins;
    pls(4'h4);
    woke;
    wevt_do;
    pls(4'h8);
    woke;
    pins;
    wr(4'h0, 32'h0, `SWC_RESP_OKAY);
    core(4'h8);
    pins;
    wevt_do;
    pls(4'h8);
    pins;
    ext;
    pins;
    end_of_test();
  end
  // cuts a hang short, far beyond the roughly 160 cycles needed
  initial begin
    #1000000;
    mismatches++;
    end_of_test();
  end
endmodule : tb_swc_sleep_ctrl
